// file: include/panel_params.svh
`ifndef PANEL_PARAMS_SVH
`define PANEL_PARAMS_SVH
`define CMD_CLOCK_SET 8'hD5
`define CMD_PRECHARGE 8'hD9
`define CMD_ROW_CFG 8'hDA
`define CMD_OFFSET 8'hD3
`define CMD_ROW_COUNT 8'hA8
`define CMD_PUMP 8'h8D
`define CMD_SCROLL_RIGHT 8'h26
`define CMD_SCROLL_LEFT 8'h27
`define CMD_SCROLL_OFF 8'h2E
`define CMD_SCROLL_ON 8'h2F
`define CMD_SCAN_NORMAL 8'hC0
`define CMD_SCAN_REMAP 8'hC8
`define CMD_DISP_OFF 8'hAE
`define CMD_DISP_ON 8'hAF
`define CMD_NO_OPERATION 8'hE3
`define SCROLL_ARGS 3'd6
`define RST_CLK_DIV 4'h0
`define RST_OSC_FREQ 4'h8
`define RST_PRECHARGE 4'h4
`define RST_ROW_CFG_ALT 1'b1
`define RST_ROW_COUNT 6'h3F
`define ROW_SPAN 7'd64
`define COL_SPAN 8'd128
`define ROW_PCLKS 8'd50
`define OSC_BASE 5'd16
`define STATUS_OFF_BIT 6
`endif

// file: include/panel_pkg.sv
package panel_pkg;
   typedef struct packed {
      logic [3:0] clk_div;
      logic [3:0] osc_freq;
      logic [3:0] precharge;
      logic alt_rows;
      logic lr_swap;
      logic remap;
      logic [5:0] row_count;
      logic [5:0] offset;
      logic [5:0] start_line;
   } panel_cfg_t;

   typedef struct packed {
      logic active;
      logic left;
      logic [2:0] start_page;
      logic [2:0] end_page;
      logic [2:0] speed;
   } scroll_cfg_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_ARG = 2'b10
   } parse_state_t;
endpackage

// file: verilog/display_clock_gen.sv
`timescale 1ns/1ns
`include "panel_params.svh"
module display_clock_gen
   import panel_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic osc_sel_i,
   input wire logic ext_tick_i,
   input wire logic [3:0] osc_freq_i,
   input wire logic [3:0] clk_div_i,
   output logic pclk_tick_o
);
   logic [4:0] osc_cnt_q, osc_cnt_d;
   logic [3:0] div_cnt_q, div_cnt_d;
   logic tick_d;
   logic src_tick;

   always_comb begin
      osc_cnt_d = osc_cnt_q + 5'd1;
      src_tick = 1'b0;
      // internal oscillator: higher setting gives shorter period
      if (osc_cnt_q >= `OSC_BASE - {1'b0, osc_freq_i}) begin
         osc_cnt_d = 5'd0;
      end
      if (osc_sel_i) begin
         src_tick = (osc_cnt_q >= `OSC_BASE - {1'b0, osc_freq_i});
      end else begin
         src_tick = ext_tick_i;
      end
      div_cnt_d = div_cnt_q;
      tick_d = 1'b0;
      if (src_tick) begin
         if (div_cnt_q >= clk_div_i) begin
            div_cnt_d = 4'h0;
            tick_d = 1'b1;
         end else begin
            div_cnt_d = div_cnt_q + 4'h1;
         end
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         osc_cnt_q <= 5'd0;
         div_cnt_q <= 4'h0;
         pclk_tick_o <= 1'b0;
      end else begin
         osc_cnt_q <= osc_cnt_d;
         div_cnt_q <= div_cnt_d;
         pclk_tick_o <= tick_d;
      end
   end
endmodule // display_clock_gen

// file: verilog/panel_command_decoder_scroll.sv
`timescale 1ns/1ns
`include "panel_params.svh"
module panel_command_decoder_scroll
   import panel_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic wr_valid_i,
   input wire logic [7:0] wr_byte_i,
   input wire logic dc_select_i,
   input wire logic rd_req_i,
   input wire logic serial_mode_i,
   input wire logic [7:0] mem_rd_data_i,
   input wire logic osc_source_select_pin_i,
   input wire logic ext_clock_i,
   input wire logic [5:0] row_query_i,
   input wire logic [6:0] col_query_i,
   output panel_cfg_t cfg_o,
   output scroll_cfg_t scroll_o,
   output logic display_on_o,
   output logic pump_on_o,
   output logic [1:0] pump_mode_o,
   output logic mem_wr_o,
   output logic [7:0] mem_wr_data_o,
   output logic rd_valid_o,
   output logic [7:0] rd_data_o,
   output logic pclk_tick_o,
   output logic precharge_o,
   output logic [5:0] row_pin_o,
   output logic row_pin_valid_o,
   output logic [5:0] mem_row_o,
   output logic [6:0] mem_col_o
);
   logic osc_meta_q, osc_sync_q, ext_meta_q, ext_sync_q, ext_prev_q;
   logic pclk_tick;
   parse_state_t state_q, state_d;
   logic [7:0] op_q, op_d;
   logic [2:0] argn_q, argn_d;
   panel_cfg_t cfg_d;
   scroll_cfg_t scr_d;
   logic disp_d, pump_en_q, pump_en_d;
   logic [1:0] pmode_d;
   logic mem_wr_d, rd_valid_d;
   logic [7:0] mem_data_d, rd_data_d;
   logic [7:0] row_tmr_q, row_tmr_d;
   logic pre_d;
   logic [6:0] col_ofs_q, col_ofs_d;
   logic [5:0] frame_row_q, frame_row_d;
   logic [3:0] frame_cnt_q, frame_cnt_d;
   logic [5:0] row_pin_d, mem_row_d;
   logic row_ok_d;
   logic [6:0] mem_col_d;

   function automatic logic [5:0] pin_of_row(input logic [5:0] r,
      input logic [5:0] n_m1, input logic [5:0] k, input logic rmp);
      if (rmp) begin
         pin_of_row = n_m1 - r + k;
      end else begin
         pin_of_row = r + k;
      end
   endfunction

   display_clock_gen u_clk (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .osc_sel_i(osc_sync_q),
      .ext_tick_i(ext_sync_q & ~ext_prev_q),
      .osc_freq_i(cfg_o.osc_freq),
      .clk_div_i(cfg_o.clk_div),
      .pclk_tick_o(pclk_tick)
   );

   always_comb begin
      state_d = state_q;
      op_d = op_q;
      argn_d = argn_q;
      cfg_d = cfg_o;
      scr_d = scroll_o;
      disp_d = display_on_o;
      pump_en_d = pump_en_q;
      pmode_d = pump_mode_o;
      mem_wr_d = 1'b0;
      mem_data_d = mem_wr_data_o;
      rd_valid_d = 1'b0;
      rd_data_d = rd_data_o;
      if (wr_valid_i && dc_select_i) begin
         mem_wr_d = 1'b1;
         mem_data_d = wr_byte_i;
      end else if (wr_valid_i && state_q == ST_ARG) begin
         argn_d = argn_q - 3'd1;
         if (argn_q == 3'd1) begin
            state_d = ST_IDLE;
         end
         if (op_q == `CMD_CLOCK_SET) begin
            cfg_d.clk_div = wr_byte_i[3:0];
            cfg_d.osc_freq = wr_byte_i[7:4];
         end else if (op_q == `CMD_PRECHARGE) begin
            cfg_d.precharge = wr_byte_i[3:0];
         end else if (op_q == `CMD_ROW_CFG) begin
            cfg_d.alt_rows = wr_byte_i[4];
            cfg_d.lr_swap = wr_byte_i[5];
         end else if (op_q == `CMD_OFFSET) begin
            cfg_d.offset = wr_byte_i[5:0];
         end else if (op_q == `CMD_ROW_COUNT) begin
            cfg_d.row_count = wr_byte_i[5:0];
         end else if (op_q == `CMD_PUMP) begin
            pump_en_d = wr_byte_i[2];
            pmode_d = {wr_byte_i[7], wr_byte_i[0]};
         end else begin
            // six scroll bytes: dummy, start page, speed, end page, 2 dummies
            if (argn_q == 3'd5) begin
               scr_d.start_page = wr_byte_i[2:0];
            end else if (argn_q == 3'd4) begin
               scr_d.speed = wr_byte_i[2:0];
            end else if (argn_q == 3'd3) begin
               scr_d.end_page = wr_byte_i[2:0];
            end
         end
      end else if (wr_valid_i) begin
         op_d = wr_byte_i;
         if (wr_byte_i == `CMD_CLOCK_SET || wr_byte_i == `CMD_PRECHARGE ||
               wr_byte_i == `CMD_ROW_CFG || wr_byte_i == `CMD_OFFSET ||
               wr_byte_i == `CMD_ROW_COUNT || wr_byte_i == `CMD_PUMP) begin
            state_d = ST_ARG;
            argn_d = 3'd1;
         end else if (wr_byte_i == `CMD_SCROLL_RIGHT ||
               wr_byte_i == `CMD_SCROLL_LEFT) begin
            state_d = ST_ARG;
            argn_d = `SCROLL_ARGS;
            scr_d.left = wr_byte_i[0];
         end else if (wr_byte_i == `CMD_SCROLL_ON) begin
            scr_d.active = 1'b1;
         end else if (wr_byte_i == `CMD_SCROLL_OFF) begin
            scr_d.active = 1'b0;
         end else if (wr_byte_i[7:6] == 2'b01) begin
            cfg_d.start_line = wr_byte_i[5:0];
         end else if (wr_byte_i == `CMD_SCAN_NORMAL) begin
            cfg_d.remap = 1'b0;
         end else if (wr_byte_i == `CMD_SCAN_REMAP) begin
            cfg_d.remap = 1'b1;
         end else if (wr_byte_i == `CMD_DISP_ON) begin
            disp_d = 1'b1;
         end else if (wr_byte_i == `CMD_DISP_OFF) begin
            disp_d = 1'b0;
         end
         // no-operation and unsupported bytes fall through unchanged
      end
      if (rd_req_i) begin
         rd_valid_d = 1'b1;
         if (dc_select_i) begin
            rd_data_d = mem_rd_data_i;
         end else if (!serial_mode_i) begin
            rd_data_d = 8'h00;
            rd_data_d[`STATUS_OFF_BIT] = ~display_on_o;
         end else begin
            rd_valid_d = 1'b0;
         end
      end
   end

   always_comb begin
      row_tmr_d = row_tmr_q;
      frame_row_d = frame_row_q;
      frame_cnt_d = frame_cnt_q;
      col_ofs_d = col_ofs_q;
      if (pclk_tick) begin
         row_tmr_d = row_tmr_q + 8'd1;
         if (row_tmr_q == `ROW_PCLKS - 8'd1) begin
            row_tmr_d = 8'd0;
            frame_row_d = frame_row_q + 6'd1;
            if (frame_row_q == cfg_o.row_count) begin
               frame_row_d = 6'd0;
               frame_cnt_d = frame_cnt_q + 4'd1;
               if (frame_cnt_q >= {1'b0, scroll_o.speed}) begin
                  frame_cnt_d = 4'd0;
                  if (scroll_o.active && scroll_o.left) begin
                     col_ofs_d = col_ofs_q - 7'd1;
                  end else if (scroll_o.active) begin
                     col_ofs_d = col_ofs_q + 7'd1;
                  end
               end
            end
         end
      end
      pre_d = row_tmr_q < {4'h0, cfg_o.precharge};
      row_pin_d = pin_of_row(row_query_i, cfg_o.row_count, cfg_o.offset,
         cfg_o.remap);
      row_ok_d = row_query_i <= cfg_o.row_count;
      mem_row_d = row_query_i + cfg_o.start_line;
      mem_col_d = col_query_i - col_ofs_q;
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         osc_meta_q <= 1'b0;
         osc_sync_q <= 1'b0;
         ext_meta_q <= 1'b0;
         ext_sync_q <= 1'b0;
         ext_prev_q <= 1'b0;
         state_q <= ST_IDLE;
         op_q <= `CMD_NO_OPERATION;
         argn_q <= 3'd0;
         cfg_o <= '{clk_div: `RST_CLK_DIV, osc_freq: `RST_OSC_FREQ,
            precharge: `RST_PRECHARGE, alt_rows: `RST_ROW_CFG_ALT,
            lr_swap: 1'b0, remap: 1'b0, row_count: `RST_ROW_COUNT,
            offset: 6'h00, start_line: 6'h00};
         scroll_o <= '0;
         display_on_o <= 1'b0;
         pump_en_q <= 1'b0;
         pump_on_o <= 1'b0;
         pump_mode_o <= 2'b00;
         mem_wr_o <= 1'b0;
         mem_wr_data_o <= 8'h00;
         rd_valid_o <= 1'b0;
         rd_data_o <= 8'h00;
         pclk_tick_o <= 1'b0;
         precharge_o <= 1'b0;
         row_tmr_q <= 8'd0;
         frame_row_q <= 6'd0;
         frame_cnt_q <= 4'd0;
         col_ofs_q <= 7'd0;
         row_pin_o <= 6'h00;
         row_pin_valid_o <= 1'b0;
         mem_row_o <= 6'h00;
         mem_col_o <= 7'h00;
      end else begin
         osc_meta_q <= osc_source_select_pin_i;
         osc_sync_q <= osc_meta_q;
         ext_meta_q <= ext_clock_i;
         ext_sync_q <= ext_meta_q;
         ext_prev_q <= ext_sync_q;
         state_q <= state_d;
         op_q <= op_d;
         argn_q <= argn_d;
         cfg_o <= cfg_d;
         scroll_o <= scr_d;
         display_on_o <= disp_d;
         pump_en_q <= pump_en_d;
         pump_on_o <= pump_en_d & disp_d;
         pump_mode_o <= pmode_d;
         mem_wr_o <= mem_wr_d;
         mem_wr_data_o <= mem_data_d;
         rd_valid_o <= rd_valid_d;
         rd_data_o <= rd_data_d;
         pclk_tick_o <= pclk_tick;
         precharge_o <= pre_d;
         row_tmr_q <= row_tmr_d;
         frame_row_q <= frame_row_d;
         frame_cnt_q <= frame_cnt_d;
         col_ofs_q <= col_ofs_d;
         row_pin_o <= row_pin_d;
         row_pin_valid_o <= row_ok_d;
         mem_row_o <= mem_row_d;
         mem_col_o <= mem_col_d;
      end
   end
endmodule // panel_command_decoder_scroll

// file: tb/host_model.sv
`timescale 1ns/1ns
`include "panel_params.svh"
module host_model (
   input wire logic clock_i,
   input wire logic rd_valid_i,
   input wire logic [7:0] rd_data_i,
   output logic wr_valid_o,
   output logic [7:0] wr_byte_o,
   output logic dc_select_o,
   output logic rd_req_o
);
   initial begin
      wr_valid_o = 1'b0;
      wr_byte_o = 8'h00;
      dc_select_o = 1'b0;
      rd_req_o = 1'b0;
   end
   // back to back bytes; the idle bus shows the inverse of the last byte
   task automatic send(input logic dc, input logic [7:0] q[$]);
      foreach (q[i]) begin
         @(negedge clock_i);
         wr_valid_o = 1'b1;
         dc_select_o = dc;
         wr_byte_o = q[i];
      end
      @(negedge clock_i);
      wr_valid_o = 1'b0;
      wr_byte_o = ~wr_byte_o;
   endtask
   task automatic read(input logic dc, output logic v, output logic [7:0] d);
      @(negedge clock_i);
      rd_req_o = 1'b1;
      dc_select_o = dc;
      @(negedge clock_i);
      rd_req_o = 1'b0;
      v = rd_valid_i;
      d = rd_data_i;
   endtask
   task automatic pump(input logic [7:0] mode);
      send(1'b0, '{`CMD_PUMP, mode, `CMD_DISP_ON});
   endtask
   // stop any motion first, then the seven setup bytes
   task automatic scroll(input logic [7:0] dir, input logic [2:0] pg);
      send(1'b0, '{`CMD_SCROLL_OFF, dir, 8'h00, 8'h00, 8'h00,
         {5'h00, pg}, 8'h00, 8'hFF});
   endtask
endmodule // host_model

// file: tb/panel_cmd_assertions.sv
`timescale 1ns/1ns
`include "panel_params.svh"
module panel_cmd_checker
   import panel_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic wr_valid_i,
   input wire logic [7:0] wr_byte_i,
   input wire logic dc_select_i,
   input wire logic rd_req_i,
   input wire logic serial_mode_i,
   input wire logic [7:0] mem_rd_data_i,
   input wire logic [5:0] row_query_i,
   input wire panel_cfg_t cfg_o,
   input wire scroll_cfg_t scroll_o,
   input wire logic display_on_o,
   input wire logic pump_on_o,
   input wire logic mem_wr_o,
   input wire logic [7:0] mem_wr_data_o,
   input wire logic rd_valid_o,
   input wire logic [7:0] rd_data_o,
   input wire logic [5:0] row_pin_o,
   input wire logic [5:0] mem_row_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (rst_i);
   logic cmd;
   logic [2:0] owed_q, owed_d;
   // parameter bytes still owed to the last command are not decoded
   always_comb begin
      owed_d = owed_q;
      if (wr_valid_i && !dc_select_i) begin
         if (owed_q != 3'd0) begin
            owed_d = owed_q - 3'd1;
         end else if (wr_byte_i == `CMD_SCROLL_RIGHT ||
               wr_byte_i == `CMD_SCROLL_LEFT) begin
            owed_d = 3'd6;
         end else if (wr_byte_i == `CMD_CLOCK_SET ||
               wr_byte_i == `CMD_PRECHARGE || wr_byte_i == `CMD_ROW_CFG ||
               wr_byte_i == `CMD_OFFSET || wr_byte_i == `CMD_ROW_COUNT ||
               wr_byte_i == `CMD_PUMP) begin
            owed_d = 3'd1;
         end
      end
   end
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         owed_q <= 3'd0;
      end else begin
         owed_q <= owed_d;
      end
   end
   assign cmd = wr_valid_i && !dc_select_i && owed_q == 3'd0;
   a_reset_vals: assert property (
      $past(rst_i) |-> cfg_o.clk_div == 4'h0 && cfg_o.osc_freq == 4'h8
      && cfg_o.precharge == 4'h4) else $error("reset values wrong");
   a_data_write: assert property (
      wr_valid_i && dc_select_i |=> mem_wr_o
      && mem_wr_data_o == $past(wr_byte_i)) else $error("data not written");
   a_status_read: assert property (
      rd_req_i && !dc_select_i && !serial_mode_i |=> rd_valid_o
      && rd_data_o == {1'b0, !$past(display_on_o), 6'h00})
      else $error("status read wrong");
   a_serial_refuse: assert property (
      rd_req_i && !dc_select_i && serial_mode_i |=> !rd_valid_o)
      else $error("status answered in serial mode");
   a_mem_read: assert property (
      rd_req_i && dc_select_i |=> rd_valid_o
      && rd_data_o == $past(mem_rd_data_i)) else $error("memory read wrong");
   a_no_op: assert property (
      cmd && wr_byte_i == `CMD_NO_OPERATION |=> $stable(cfg_o)
      && $stable(scroll_o)) else $error("no operation changed state");
   a_pump_disp: assert property (
      pump_on_o |-> display_on_o) else $error("pump on with display off");
   a_scroll_stop: assert property (
      cmd && wr_byte_i == `CMD_SCROLL_OFF |=> !scroll_o.active)
      else $error("scroll still active");
   a_start_line: assert property (
      cmd && wr_byte_i[7:6] == 2'b01 |=>
      cfg_o.start_line == $past(wr_byte_i[5:0])) else $error("start line");
   a_mem_row: assert property (
      !$past(rst_i) |-> mem_row_o == $past(row_query_i)
      + $past(cfg_o.start_line)) else $error("memory row wrong");
   a_remap_pin: assert property (
      !$past(rst_i) && $past(cfg_o.remap) |-> row_pin_o ==
      $past(cfg_o.row_count) - $past(row_query_i) + $past(cfg_o.offset))
      else $error("remapped row pin wrong");
endmodule // panel_cmd_checker
bind panel_command_decoder_scroll panel_cmd_checker CHK (.clock_i, .rst_i,
   .wr_valid_i, .wr_byte_i, .dc_select_i, .rd_req_i, .serial_mode_i,
   .mem_rd_data_i, .row_query_i, .cfg_o, .scroll_o, .display_on_o,
   .pump_on_o, .mem_wr_o, .mem_wr_data_o, .rd_valid_o, .rd_data_o,
   .row_pin_o, .mem_row_o);

// file: tb/panel_command_decoder_scroll_tb.sv
`timescale 1ns/1ns
`include "panel_params.svh"
module panel_command_decoder_scroll_tb import panel_pkg::*;;
   logic clock_i = 1'b0, rst_i = 1'b1, osc_pin = 1'b1, serial = 1'b0;
   logic [5:0] row_q = 6'h00;
   logic wr_v, dc, rd_r, disp, pump, rd_v, tick, pin_v, v, pre, mwr;
   logic ext_clk = 1'b0, ext_run = 1'b0;
   logic [7:0] wr_b, rd_d, d, mdat;
   logic [1:0] pmode;
   logic [5:0] pin, mrow;
   logic [6:0] mcol;
   panel_cfg_t cfg, keep;
   scroll_cfg_t scr;
   int failures = 0, checks = 0, n;
   logic [7:0] modes [3] = '{8'h14, 8'h94, 8'h95};
   // command, parameter, field selector, expected field value
   logic [7:0] rows [7][4] = '{'{8'hD5, 8'hF3, 8'h00, 8'h03},
      '{8'hD5, 8'h0F, 8'h01, 8'h00}, '{8'hDA, 8'h02, 8'h02, 8'h00},
      '{8'hDA, 8'h22, 8'h03, 8'h01}, '{8'hDA, 8'h02, 8'h03, 8'h00},
      '{8'hA8, 8'h0F, 8'h04, 8'h0F}, '{8'hD3, 8'h08, 8'h05, 8'h08}};
   always #50 clock_i = ~clock_i;
   // external source clock, six system clocks a period while running
   always begin
      repeat (3) @(negedge clock_i);
      ext_clk = ext_run & ~ext_clk;
   end
   panel_command_decoder_scroll DUT (.clock_i, .rst_i, .wr_valid_i(wr_v),
      .wr_byte_i(wr_b), .dc_select_i(dc), .rd_req_i(rd_r),
      .serial_mode_i(serial), .mem_rd_data_i(8'hA5),
      .osc_source_select_pin_i(osc_pin), .ext_clock_i(ext_clk),
      .row_query_i(row_q), .col_query_i(7'h00), .cfg_o(cfg),
      .scroll_o(scr), .display_on_o(disp), .pump_on_o(pump),
      .pump_mode_o(pmode), .mem_wr_o(mwr), .mem_wr_data_o(mdat),
      .rd_valid_o(rd_v), .rd_data_o(rd_d), .pclk_tick_o(tick),
      .precharge_o(pre), .row_pin_o(pin),
      .row_pin_valid_o(pin_v), .mem_row_o(mrow), .mem_col_o(mcol));
   host_model HOST (.clock_i, .rd_valid_i(rd_v), .rd_data_i(rd_d),
      .wr_valid_o(wr_v), .wr_byte_o(wr_b), .dc_select_o(dc), .rd_req_o(rd_r));
   task automatic check(input string s, input logic [32:0] g, e);
      checks++;
      if (g !== e) begin
         failures++;
         $display("FAIL %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic print_verdict;
      $display("failures %0d checks %0d", failures, checks);
      if (failures == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] b);
      HOST.send(1'b0, '{b});
   endtask
   function automatic logic [5:0] field(input logic [7:0] i);
      case (i)
         0: return 6'(cfg.clk_div);
         1: return 6'(cfg.osc_freq);
         2: return 6'(cfg.alt_rows);
         3: return 6'(cfg.lr_swap);
         4: return cfg.row_count;
         default: return cfg.offset;
      endcase
   endfunction
   task automatic query(input logic [5:0] r, pe, input logic ve,
      input logic [5:0] me);
      @(negedge clock_i);
      row_q = r;
      @(negedge clock_i);
      check("row pin", {pin_v, pin, mrow}, {ve, pe, me});
   endtask
   task automatic ticks(input int lo, hi);
      n = 0;
      repeat (160) @(negedge clock_i) n += int'(tick);
      check("tick count", n >= lo && n <= hi, 1'b1);
   endtask
   task automatic pres(input int e);
      repeat (8) @(negedge clock_i);
      n = 0;
      repeat (200) @(negedge clock_i) n += int'(pre);
      check("precharge", n, e);
   endtask
   task automatic step(input logic [6:0] e);
      logic [6:0] p;
      p = mcol;
      for (int i = 0; i < 4000 && mcol === p; i++) @(negedge clock_i);
      check("column", mcol, e);
   endtask
   initial begin
      repeat (10) @(posedge clock_i);
      @(negedge clock_i);
      rst_i = 1'b0;
      check("reset cfg", cfg,
         {4'h0, 4'h8, 4'h4, 3'b100, 6'h3F, 12'h000});
      HOST.read(1'b0, v, d);
      check("status off", {v, d}, 9'h140);
      foreach (rows[i]) begin
         HOST.send(1'b0, '{rows[i][0], rows[i][1]});
         check("field", field(rows[i][2]), rows[i][3]);
      end
      wr(`CMD_SCAN_REMAP);
      wr(8'h48);
      query(6'd0, 6'd23, 1'b1, 6'd8);
      query(6'd15, 6'd8, 1'b1, 6'd23);
      query(6'd16, 6'd7, 1'b0, 6'd24);
      wr(`CMD_SCAN_NORMAL);
      query(6'd63, 6'd7, 1'b0, 6'd7);
      foreach (modes[i]) begin
         HOST.pump(modes[i]);
         check("pump", {pump, pmode}, {1'b1, modes[i][7], modes[i][0]});
         HOST.read(1'b0, v, d);
         check("status on", {v, d}, 9'h100);
         wr(`CMD_DISP_OFF);
         check("pump off", pump, 1'b0);
      end
      serial = 1'b1;
      HOST.read(1'b0, v, d);
      check("serial status", v, 1'b0);
      HOST.read(1'b1, v, d);
      check("memory read", {v, d}, 9'h1A5);
      serial = 1'b0;
      keep = cfg;
      HOST.send(1'b1, '{`CMD_SCAN_REMAP, `CMD_DISP_ON});
      check("memory write", {mwr, mdat}, 9'h1AF);
      check("data bytes", {cfg, disp}, {keep, 1'b0});
      wr(`CMD_NO_OPERATION);
      check("no operation", cfg, keep);
      HOST.send(1'b0, '{`CMD_CLOCK_SET, 8'hF0});
      ticks(79, 81);
      HOST.send(1'b0, '{`CMD_CLOCK_SET, 8'hF3});
      ticks(19, 21);
      osc_pin = 1'b0;
      repeat (4) @(negedge clock_i);
      ticks(0, 0);
      ext_run = 1'b1;
      ticks(5, 8);
      ext_run = 1'b0;
      osc_pin = 1'b1;
      HOST.send(1'b0, '{`CMD_CLOCK_SET, 8'hF0});
      pres(16);
      HOST.send(1'b0, '{`CMD_PRECHARGE, 8'h02});
      pres(8);
      HOST.scroll(`CMD_SCROLL_RIGHT, 3'd7);
      check("scroll setup", scr, 11'h038);
      wr(`CMD_SCROLL_ON);
      step(7'd127);
      HOST.scroll(`CMD_SCROLL_LEFT, 3'd7);
      wr(`CMD_SCROLL_ON);
      step(7'd0);
      step(7'd1);
      wr(`CMD_SCROLL_OFF);
      repeat (3200) @(negedge clock_i);
      check("scroll stopped", {scr.active, mcol}, 8'h01);
      rst_i = 1'b1;
      repeat (2) @(negedge clock_i);
      rst_i = 1'b0;
      check("reset cfg again", cfg,
         {4'h0, 4'h8, 4'h4, 3'b100, 6'h3F, 12'h000});
      check("reset scroll", {scr, disp, mcol}, 19'h00000);
      HOST.read(1'b0, v, d);
      check("status after reset", {v, d}, 9'h140);
      print_verdict();
   end
   initial begin
      repeat (40000) @(posedge clock_i);
      failures++;
      print_verdict();
   end
endmodule // panel_command_decoder_scroll_tb
